/* File: design/sio_pkg.sv */
// Purpose: shared constants and carriers for the shared i/o port with change notify
// Assumes: 16-bit port, up to 21 change-sense pins split over a low and high enable word
// Notes: no register bus; all control words are plain ports
package sio_pkg;
    localparam int PORT_W = 16;
    localparam int CN_W = 21;
    localparam int CN_LO_W = 16;
    localparam int CN_HI_W = 5;
    localparam logic [15:0] DIR_RESET = 16'hffff;
    localparam logic [15:0] LAT_RESET = 16'h0000;
    localparam logic [15:0] ODC_RESET = 16'h0000;
    localparam logic [15:0] ANA_RESET = 16'h0000;
    localparam logic [15:0] CN_EN_RESET = 16'h0000;
    localparam logic [15:0] PU_RESET = 16'h0000;
    localparam int SYNC_STAGES = 2;

    // software write strobe for one port word
    typedef struct packed {
        logic wr;
        logic [15:0] data;
    } sio_wr_s;

    // per-pin driver controls presented to a pad
    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
    } sio_pad_s;
endpackage

/* File: design/sio_sync.sv */
// Purpose: two-stage synchroniser bank for pin inputs
// Assumes: inputs arrive asynchronously to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sio_sync #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sio_sync width must be positive");
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: design/sio_port.sv */
// Purpose: shared general-purpose i/o port with change notification
// Assumes: peripheral enable/drive arrive on ref_clk; pins are asynchronous
// Notes: change-sense pins are port bits 0..15 plus cn_ext_in bits 16..20
// Operation
// RULE1: enabled peripheral actively driving a pin disables the port driver; pin stays readable
// RULE2: enabled peripheral not driving leaves pin to port latch and direction
// RULE3: port output never loops back into a sharing peripheral input
// RULE4: direction bit one means input, zero means output
// RULE5: reset sets every direction bit, making all pins inputs
// RULE6: latch read returns the latch; latch write updates it
// RULE7: pin-level read returns pins; pin-level write updates the latch
// RULE8: unimplemented bits read zero in latch, direction and pin level, and stay disabled
// RULE9: open-drain bit set makes the pin open-drain instead of push-pull
// RULE10: analog config resets to zero so analog-capable pins start analog
// RULE11: pins configured analog read zero in the pin-level register
// RULE12: software waits one cycle between port write or direction change and read; here pin_level_reg lags a write by three cycles
// RULE13: change on any enabled input raises interrupt request, up to 21 pins
// RULE14: each change pin has an enable bit in low and high enable words
// RULE15: each change pin has a pull-up bit in low and high pull-up words
// RULE16: software keeps pull-ups off on pins used as digital outputs
// RULE17: compare each enabled pin with its previous sample, request on difference
`timescale 1ns/1ps
`default_nettype none
module sio_port #(
    parameter logic [15:0] IMPL_MASK = 16'hffff,
    parameter logic [15:0] ANALOG_CAPABLE = 16'h000f,
    parameter logic [15:0] ODC_CAPABLE = 16'hffff
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // software writes
    input wire sio_pkg::sio_wr_s dir_wr,
    input wire sio_pkg::sio_wr_s lat_wr,
    input wire sio_pkg::sio_wr_s port_wr,
    input wire sio_pkg::sio_wr_s odc_wr,
    input wire sio_pkg::sio_wr_s ana_wr,
    input wire sio_pkg::sio_wr_s cn_en_lo_wr,
    input wire sio_pkg::sio_wr_s cn_en_hi_wr,
    input wire sio_pkg::sio_wr_s pu_lo_wr,
    input wire sio_pkg::sio_wr_s pu_hi_wr,
    // software reads
    output logic [15:0] pin_direction_reg,
    output logic [15:0] output_latch_reg,
    output logic [15:0] pin_level_reg,
    output logic [15:0] open_drain_ctrl_reg,
    output logic [15:0] analog_pin_config_reg,
    output logic [15:0] change_irq_enable_lo,
    output logic [15:0] change_irq_enable_hi,
    output logic [15:0] weak_pullup_enable_lo,
    output logic [15:0] weak_pullup_enable_hi,
    // shared peripherals
    input wire logic [15:0] periph_enable,
    input wire logic [15:0] periph_oe,
    input wire logic [15:0] periph_out,
    output logic [15:0] periph_in,
    // pads
    input wire logic [15:0] pad_in,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe,
    output logic [20:0] pullup_on,
    input wire logic [4:0] cn_ext_in,
    // change notification
    output logic change_irq
);
    logic [15:0] dir_r;
    logic [15:0] lat_r;
    logic [15:0] odc_r;
    logic [15:0] ana_r;
    logic [20:0] cn_en_r;
    logic [20:0] pu_r;
    logic [15:0] pad_sync;
    logic [4:0] ext_sync;
    logic [20:0] cn_now;
    logic [20:0] cn_prev_reg;
    logic cn_primed_reg;
    logic [15:0] pin_level_next;
    logic [15:0] periph_in_next;
    logic [15:0] own;
    sio_pkg::sio_pad_s pad;

    // the change words and pad views are laid out for this split only
    if (sio_pkg::CN_LO_W + sio_pkg::CN_HI_W != sio_pkg::CN_W || sio_pkg::CN_LO_W != sio_pkg::PORT_W)
    begin : g_bad_split
        $error("sio_port change-sense split does not match port width");
    end

    // a port with no implemented bit cannot serve any rule
    if (IMPL_MASK == 16'h0000)
    begin : g_bad_mask
        $error("sio_port needs at least one implemented bit");
    end

    // direction: reset all inputs
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            dir_r <= sio_pkg::DIR_RESET; // RULE5
        else if (dir_wr.wr)
            dir_r <= dir_wr.data & IMPL_MASK; // RULE8
    end

    // latch: written either through latch view or pin-level view
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            lat_r <= sio_pkg::LAT_RESET;
        else if (lat_wr.wr)
            lat_r <= lat_wr.data & IMPL_MASK; // RULE6
        else if (port_wr.wr)
            lat_r <= port_wr.data & IMPL_MASK; // RULE7
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            odc_r <= sio_pkg::ODC_RESET;
        else if (odc_wr.wr)
            odc_r <= odc_wr.data & ODC_CAPABLE & IMPL_MASK;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            ana_r <= sio_pkg::ANA_RESET; // RULE10
        else if (ana_wr.wr)
            ana_r <= ana_wr.data;
    end

    // change enables and pull-ups span two words each
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cn_en_r <= {sio_pkg::CN_EN_RESET[4:0], sio_pkg::CN_EN_RESET};
            pu_r <= {sio_pkg::PU_RESET[4:0], sio_pkg::PU_RESET};
        end
        else
        begin
            if (cn_en_lo_wr.wr)
                cn_en_r[15:0] <= cn_en_lo_wr.data; // RULE14
            if (cn_en_hi_wr.wr)
                cn_en_r[20:16] <= cn_en_hi_wr.data[4:0]; // RULE14
            if (pu_lo_wr.wr)
                pu_r[15:0] <= pu_lo_wr.data; // RULE15
            if (pu_hi_wr.wr)
                pu_r[20:16] <= pu_hi_wr.data[4:0]; // RULE15
        end
    end

    sio_sync #(.WIDTH(16)) u_pad_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(pad_in),
        .sync_out(pad_sync)
    );

    sio_sync #(.WIDTH(5)) u_ext_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(cn_ext_in),
        .sync_out(ext_sync)
    );

    // pad drive: peripheral owns a pin only while enabled and driving
    always_comb
    begin
        own = periph_enable & periph_oe; // RULE1 RULE2
        pad.out = '0;
        pad.oe = '0;
        for (int i = 0; i < 16; i++)
        begin
            if (!IMPL_MASK[i])
            begin
                pad.out[i] = 1'b0;
                pad.oe[i] = 1'b0; // RULE8
            end
            else if (own[i])
            begin
                pad.out[i] = periph_out[i];
                pad.oe[i] = 1'b1; // RULE1
            end
            else if (odc_r[i])
            begin
                // open drain: only ever pull low
                pad.out[i] = 1'b0;
                pad.oe[i] = !dir_r[i] && !lat_r[i]; // RULE9 RULE4
            end
            else
            begin
                pad.out[i] = lat_r[i];
                pad.oe[i] = !dir_r[i]; // RULE2 RULE4
            end
        end
    end

    assign pad_out = pad.out;
    assign pad_oe = pad.oe;
    assign pullup_on = pu_r;

    // read views and peripheral input; analog pins read low
    always_comb
    begin
        pin_level_next = pad_sync & IMPL_MASK & ~(~ana_r & ANALOG_CAPABLE); // RULE7 RULE11 RULE8
        // a port-driven pin feeds the peripheral zero, avoiding loop-through
        periph_in_next = pad_sync & ~(~dir_r & ~own) & IMPL_MASK; // RULE3
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_level_reg <= '0;
            periph_in <= '0;
        end
        else
        begin
            pin_level_reg <= pin_level_next;
            periph_in <= periph_in_next;
        end
    end

    assign pin_direction_reg = dir_r & IMPL_MASK; // RULE8
    assign output_latch_reg = lat_r & IMPL_MASK; // RULE6
    assign open_drain_ctrl_reg = odc_r;
    assign analog_pin_config_reg = ana_r;
    assign change_irq_enable_lo = cn_en_r[15:0];
    assign change_irq_enable_hi = {11'h000, cn_en_r[20:16]};
    assign weak_pullup_enable_lo = pu_r[15:0];
    assign weak_pullup_enable_hi = {11'h000, pu_r[20:16]};

    // change detector on synchronised levels; sleep-time detection relies on
    // ref_clk still toggling, a limitation of this synchronous version
    assign cn_now = {ext_sync, pad_sync};

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cn_prev_reg <= '0;
            cn_primed_reg <= 1'b0;
        end
        else
        begin
            cn_prev_reg <= cn_now; // RULE17
            cn_primed_reg <= 1'b1;
        end
    end

    // first cycle after reset has no valid history
    assign change_irq = cn_primed_reg && |((cn_now ^ cn_prev_reg) & cn_en_r); // RULE13 RULE17

    a_dir_reset_input: assert property (@(posedge ref_clk) $rose(rstn) |-> pin_direction_reg == IMPL_MASK) // RULE5
        else $error("direction not all inputs after reset");

    a_port_write_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
        port_wr.wr && !lat_wr.wr |=> output_latch_reg == ($past(port_wr.data) & IMPL_MASK)) // RULE7
        else $error("pin-level write did not reach latch");

    a_latch_write: assert property (@(posedge ref_clk) disable iff (!rstn)
        lat_wr.wr |=> output_latch_reg == ($past(lat_wr.data) & IMPL_MASK)) // RULE6
        else $error("latch write lost");

    a_periph_owns_pad: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pad_oe & IMPL_MASK & periph_enable & periph_oe) == (IMPL_MASK & periph_enable & periph_oe)) // RULE1
        else $error("driving peripheral lost pad");

    a_input_no_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pad_oe & dir_r & ~(periph_enable & periph_oe)) == 16'h0000) // RULE4
        else $error("input pin driven by port");

    a_odc_no_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pad_oe & pad_out & odc_r & ~(periph_enable & periph_oe)) == 16'h0000) // RULE9
        else $error("open-drain pin driven high");

    a_analog_reads_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 (pin_level_reg & $past(~ana_r & ANALOG_CAPABLE)) == 16'h0000) // RULE11
        else $error("analog pin read nonzero");

    a_no_loop_through: assert property (@(posedge ref_clk) disable iff (!rstn)
        ##1 (periph_in & $past(~dir_r & ~(periph_enable & periph_oe))) == 16'h0000) // RULE3
        else $error("port output looped to peripheral");

    a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        ((pin_direction_reg | output_latch_reg | pin_level_reg | pad_oe) & ~IMPL_MASK) == 16'h0000) // RULE8
        else $error("unimplemented bit active");

    a_change_irq: assert property (@(posedge ref_clk) disable iff (!rstn)
        cn_primed_reg && ((cn_now ^ $past(cn_now)) & cn_en_r) != 21'h00000 |-> change_irq) // RULE13
        else $error("enabled change missed");

    a_analog_reset: assert property (@(posedge ref_clk) $rose(rstn) |-> analog_pin_config_reg == 16'h0000) // RULE10
        else $error("analog config reset wrong");
endmodule
`default_nettype wire

/* File: tb/sio_pin_model.sv */
// Purpose: far side of the port pins: external drivers and weak pull-ups
// Assumes: port drive wins over an external driver; contention not modelled
// Notes: a pin nobody drives and with no pull-up toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module sio_pin_model (
    // clock
    input wire logic ref_clk,
    // from the port
    input wire logic [15:0] pad_out,
    input wire logic [15:0] pad_oe,
    input wire logic [15:0] pull_en,
    // external drivers
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    // to the port
    output logic [15:0] pad_in
);
    logic [15:0] float_reg = 16'h0000;

    // floating pins wander so a stale level never passes for a real one
    always @(posedge ref_clk)
        float_reg <= ~float_reg;

    always_comb
        for (int i = 0; i < 16; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pull_en[i] ? 1'b1 : float_reg[i];
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the shared i/o port
// Assumes: bit 15 left unimplemented, pins 3:0 analog-capable
// Notes: drivers queue expected values, a watcher compares them
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {int sel; logic [20:0] exp;} sio_note_s;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    sio_pkg::sio_wr_s wrs [9] = '{default: '0};
    logic [15:0] rd [9];
    logic [15:0] periph_enable = 16'h0000, periph_oe = 16'h0000, periph_out = 16'h0000;
    logic [15:0] ext_en = 16'hffff, ext_val = 16'h0000;
    logic [4:0] cn_ext_in = 5'h00;
    logic [15:0] periph_in, pad_in, pad_out, pad_oe;
    logic [20:0] pullup_on, irq_cnt;
    logic change_irq;
    logic [31:0] r;
    int seed = 32'h26be;
    int fails = 0, num_checks = 0;
    sio_note_s q[$];
    sio_note_s n;
    event look;

    always #12.5 ref_clk = ~ref_clk;

    sio_port #(.IMPL_MASK(16'h7fff)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .dir_wr(wrs[0]), .lat_wr(wrs[1]), .port_wr(wrs[2]), .odc_wr(wrs[3]), .ana_wr(wrs[4]),
        .cn_en_lo_wr(wrs[5]), .cn_en_hi_wr(wrs[6]), .pu_lo_wr(wrs[7]), .pu_hi_wr(wrs[8]),
        .pin_direction_reg(rd[0]), .output_latch_reg(rd[1]), .pin_level_reg(rd[2]),
        .open_drain_ctrl_reg(rd[3]), .analog_pin_config_reg(rd[4]), .change_irq_enable_lo(rd[5]),
        .change_irq_enable_hi(rd[6]), .weak_pullup_enable_lo(rd[7]), .weak_pullup_enable_hi(rd[8]),
        .periph_enable(periph_enable), .periph_oe(periph_oe), .periph_out(periph_out),
        .periph_in(periph_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pullup_on(pullup_on), .cn_ext_in(cn_ext_in), .change_irq(change_irq));

    sio_pin_model pins (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_en(pullup_on[15:0]), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    function automatic logic [20:0] obs(input int s);
        case (s)
            9: obs = {5'h00, pad_out};
            10: obs = {5'h00, pad_oe};
            11: obs = {5'h00, periph_in};
            12: obs = pullup_on;
            13: obs = irq_cnt;
            default: obs = {5'h00, rd[s]};
        endcase
    endfunction

    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input int s, input logic [20:0] e);
        q.push_back('{s, e});
        ->look;
    endtask

    task automatic wr(input int i, input logic [15:0] d);
        @(posedge ref_clk);
        wrs[i] <= '{wr: 1'b1, data: d};
        @(posedge ref_clk);
        wrs[i] <= '{wr: 1'b0, data: 16'h0000};
        #1;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // flips one change-sense pin and counts the request cycles that follow
    task automatic poke(input int b);
        @(posedge ref_clk);
        if (b < 16)
            ext_val[b] <= ~ext_val[b];
        else
            cn_ext_in[b-16] <= ~cn_ext_in[b-16];
        irq_cnt = 0;
        repeat (8)
        begin
            @(posedge ref_clk);
            #1;
            if (change_irq === 1'b1)
                irq_cnt++;
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
        forever
        begin
            @look;
            while (q.size() > 0)
            begin
                n = q.pop_front();
                chk(obs(n.sel), n.exp);
            end
        end

    initial
    begin
        #100000;
        fails++;
        wrap_up;
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        cyc(1);
        note(0, 21'h07fff);
        for (int s = 1; s < 9; s++)
            note(s, 21'h00000);
        note(10, 21'h00000);
        $display("test reset done");
        repeat (4)
        begin
            r = $random(seed);
            wr(1, r[15:0]);
            note(1, {5'h00, r[15:0] & 16'h7fff});
        end
        wr(2, 16'hc3a5);
        note(1, 21'h043a5);
        wr(0, 16'h0000);
        note(10, 21'h07fff);
        note(9, 21'h043a5);
        cyc(4);
        note(2, 21'h043a0);
        wr(4, 16'hffff);
        cyc(4);
        note(2, 21'h043a5);
        $display("test latch and pins done");
        @(posedge ref_clk);
        periph_enable <= 16'h00f0;
        periph_oe <= 16'h0030;
        periph_out <= 16'h0010;
        cyc(5);
        note(9, 21'h04395);
        note(2, 21'h04395);
        note(11, 21'h00010);
        @(posedge ref_clk);
        periph_enable <= 16'h0000;
        $display("test sharing done");
        wr(3, 16'h00ff);
        wr(1, 16'h5af0);
        note(9, 21'h05a00);
        note(10, 21'h07f0f);
        wr(3, 16'h0000);
        $display("test open drain done");
        wr(0, 16'hffff);
        @(posedge ref_clk);
        ext_en <= 16'hff0f;
        wr(7, 16'h00f0);
        wr(8, 16'h0003);
        note(12, 21'h300f0);
        cyc(4);
        note(2, 21'h000f0);
        wr(6, 16'hffff);
        note(6, 21'h0001f);
        wr(6, 16'h0001);
        wr(5, 16'h0001);
        cyc(4);
        poke(0);
        note(13, 21'h00001);
        poke(1);
        note(13, 21'h00000);
        poke(16);
        note(13, 21'h00001);
        $display("test change notify done");
        #1;
        wrap_up;
    end
endmodule
`default_nettype wire
